// [hw/pmx_consts.svh]
// Constants for the port A / port B alternate-function pin mux.
// Assumes inclusion by bare name from the mux package and modules.
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// Interface configuration field encodings
`define PMX_IFC_PORTS 2'h0
`define PMX_IFC_BUS 2'h2
`define PMX_IFC_SLAVE 2'h3

// Bit positions inside the FIFO pin polarity register
`define PMX_POL_OE_BIT 4
`define PMX_POL_COMMIT_BIT 5

// Bit positions inside the wake control register
`define PMX_WAKE_GATE_BIT 1
`define PMX_WAKE_POL_BIT 4
`define PMX_WAKE_SEL_BIT 7

// Port A direction bit that must be clear for the wake input
`define PMX_WAKE_DIR_BIT 3

// Pin indices in the pin vector
`define PMX_NPINS 9
`define PMX_IDX_PORT_A_PIN2 0
`define PMX_IDX_PORT_A_PIN3 1
`define PMX_IDX_PORT_A_PIN4 2
`define PMX_IDX_PORT_A_PIN5 3
`define PMX_IDX_PORT_A_PIN6 4
`define PMX_IDX_PORT_A_PIN7 5
`define PMX_IDX_PORT_B_PIN0 6
`define PMX_IDX_PORT_B_PIN2 8

// Reset values
`define PMX_RST_PIN_OE 1'b0
`define PMX_RST_PIN_O 1'b0
`define PMX_RST_LVL 1'b1
`define PMX_RST_FLAG 1'b0

`endif

// [hw/pmx_pkg.sv]
// Types shared by the pin mux ends.
// Assumes the constants header is on the include path.
`include "pmx_consts.svh"

package pmx_pkg;
    // Operating mode decoded from the interface configuration field
    typedef enum logic [1:0] {pmx_mode_ports, pmx_mode_bus, pmx_mode_slave} pmx_mode_t;
    // One bit per muxed pin
    typedef logic [`PMX_NPINS-1:0] pmx_pins_t;
    // Three low data-bus lines
    typedef logic [2:0] pmx_data_t;
endpackage

// [hw/pmx_if.sv]
// Pin-level carrier between the device mux and the external FIFO master.
// Assumes a weak pull-up on every pin when neither end drives it.
`timescale 1ns/10ps

interface pmx_if;
    import pmx_pkg::*;
    pmx_pins_t dev_o;
    pmx_pins_t dev_oe;
    pmx_pins_t mst_o;
    pmx_pins_t mst_oe;
    pmx_pins_t pin_lvl;

    // Resolved wire level: device first, then master, else pull-up
    assign pin_lvl = (dev_oe & dev_o) | (~dev_oe & mst_oe & mst_o) | (~dev_oe & ~mst_oe);

    modport dev (input pin_lvl, output dev_o, output dev_oe);
    modport mst (input pin_lvl, output mst_o, output mst_oe);
endinterface

// [hw/pmx_pin_cell.sv]
// One muxed pin: registered output, enable and sampled input.
// Assumes pin_i is synchronous to clk_sys.
`timescale 1ns/10ps
`include "pmx_consts.svh"

module pmx_pin_cell (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic alt_sel, // Alternate function owns the pin
    input wire logic alt_out, // Alternate output value
    input wire logic alt_oe, // Alternate drive enable
    input wire logic gp_out, // Port output latch value
    input wire logic gp_oe, // Port direction, 1 = output
    input wire logic pin_i, // Level seen on the pin
    output logic pin_o_ff, // Value driven on the pin
    output logic pin_oe_ff, // Drive enable
    output logic pin_in_ff // Sampled pin level
);
    // Select function and register the driver
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_o_ff <= `PMX_RST_PIN_O;
            pin_oe_ff <= `PMX_RST_PIN_OE;
        end else begin
            pin_o_ff <= alt_sel ? alt_out : gp_out;
            pin_oe_ff <= alt_sel ? alt_oe : gp_oe;
        end
    end

    // Sample the pin
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_in_ff <= `PMX_RST_LVL;
        end else begin
            pin_in_ff <= pin_i;
        end
    end
endmodule

// [hw/pmx_device.sv]
// Device end: muxes port A pins 2..7 and port B pins 0..2 between
// general-purpose port bits and the data bus, slave FIFO and wake alternates.
// Assumes configuration inputs come from core registers on clk_sys and
// that the FIFO core reads the normalised strobes it gets from here.
`timescale 1ns/10ps
`include "pmx_consts.svh"

// Operation
// - Config field picks port bit or output-enable input
// - Output-enable input only, polarity from bit 4
// - Port A pin3 wake when selected, input
// - Wake gated by bit 1, polarity bit 4
// - Wake edge in suspend restarts oscillator, interrupts
// - Asserted gated wake refuses suspend
// - Pins 4,5 input-only FIFO selects in slave
// - Pin 6 packet commit input in slave
// - Commit polarity follows polarity bit 5
// - Pin 7: port, flag D, or chip select
// - Flag D drives programmable status flag out
// - Deasserted chip select blocks FIFO strobes
// - Port B pins 0..2 become data bus
// - Otherwise each pin is a port bit
module pmx_device (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    pmx_if.dev bif, // Pins toward the FIFO master
    input wire logic [1:0] interface_config, // Interface configuration field
    input wire logic [5:4] fifo_pin_polarity, // Output-enable and commit polarity
    input wire logic port_a_alt_config7, // Pin 7 flag D select
    input wire logic second_wake_select, // Wake control bit 7
    input wire logic second_wake_gate, // Wake control bit 1
    input wire logic second_wake_polarity, // Wake control bit 4
    input wire logic [7:2] port_a_out, // Port A output latch
    input wire logic [7:2] port_a_direction, // Port A direction, 1 = output
    input wire logic [2:0] port_b_out, // Port B output latch
    input wire logic [2:0] port_b_direction, // Port B direction, 1 = output
    input wire pmx_pkg::pmx_data_t fifo_data_out, // Data from the FIFO core
    input wire logic fifo_data_drive, // FIFO core wants to drive data
    input wire logic flag_d_value, // Programmable flag D from FIFO core
    input wire logic cpu_suspended, // Processor is in suspend
    output logic [7:2] port_a_in, // Port A pin levels
    output logic [2:0] port_b_in, // Port B pin levels
    output pmx_pkg::pmx_data_t fifo_data_in, // Data lines toward FIFO core
    output logic slave_out_enable, // Normalised output enable, active high
    output logic [1:0] fifo_select, // FIFO address selects
    output logic packet_commit, // Normalised packet commit, active high
    output logic chip_selected, // Chip select seen asserted
    output logic wake_osc_restart, // Pulse: restart the oscillator
    output logic wake_irq, // Pulse: wake interrupt to processor
    output logic suspend_inhibit // Level: suspend refused
);
    import pmx_pkg::*;

    pmx_mode_t mode;
    logic slave;
    logic bus;
    logic cs_use;
    logic flag_d_use;
    logic wake_use;
    logic cs_act;
    logic oe_act;
    logic commit_act;
    logic wake_lvl;
    logic wake_asserted;
    pmx_pins_t alt_sel;
    pmx_pins_t alt_out;
    pmx_pins_t alt_oe;
    pmx_pins_t gp_out;
    pmx_pins_t gp_oe;
    pmx_pins_t pin_o;
    pmx_pins_t pin_oe;
    pmx_pins_t pin_in;
    logic slave_oe_ff;
    logic [1:0] fifo_sel_ff;
    logic commit_ff;
    logic cs_ff;
    logic wake_prev_ff;
    logic wake_vld_ff;
    logic wake_arm_ff;
    logic osc_restart_ff;
    logic irq_ff;
    logic inhibit_ff;

    // Decode of the interface configuration field; reserved code acts as ports
    function automatic pmx_mode_t ifc_mode(input logic [1:0] ifc);
        if (ifc == `PMX_IFC_SLAVE) begin
            return pmx_mode_slave;
        end else if (ifc == `PMX_IFC_BUS) begin
            return pmx_mode_bus;
        end else begin
            return pmx_mode_ports;
        end
    endfunction

    // Level to active-high: polarity bit set means active high
    function automatic logic pin_active(input logic lvl, input logic pol);
        return pol ? lvl : ~lvl;
    endfunction

    // Mode and function selection
    always_comb begin
        mode = ifc_mode(interface_config);
        slave = (mode == pmx_mode_slave);
        bus = (mode != pmx_mode_ports);
        flag_d_use = slave && port_a_alt_config7;
        cs_use = slave && !port_a_alt_config7;
        wake_use = second_wake_select && !port_a_direction[`PMX_WAKE_DIR_BIT];
    end

    // Normalised strobes from sampled pin levels
    always_comb begin
        cs_act = cs_use ? ~pin_in[`PMX_IDX_PORT_A_PIN7] : 1'b1;
        oe_act = pin_active(pin_in[`PMX_IDX_PORT_A_PIN2], fifo_pin_polarity[`PMX_POL_OE_BIT]);
        commit_act = pin_active(pin_in[`PMX_IDX_PORT_A_PIN6], fifo_pin_polarity[`PMX_POL_COMMIT_BIT]);
        wake_lvl = pin_in[`PMX_IDX_PORT_A_PIN3];
        wake_asserted = (wake_lvl == second_wake_polarity);
    end

    // Per-pin alternate selection, value and enable
    always_comb begin
        gp_out = {port_b_out, port_a_out};
        gp_oe = {port_b_direction, port_a_direction};
        alt_sel = '0;
        alt_out = '0;
        alt_oe = '0;
        // Input-only slave pins never drive
        alt_sel[`PMX_IDX_PORT_A_PIN2] = slave;
        alt_sel[`PMX_IDX_PORT_A_PIN3] = wake_use;
        alt_sel[`PMX_IDX_PORT_A_PIN4] = slave;
        alt_sel[`PMX_IDX_PORT_A_PIN5] = slave;
        alt_sel[`PMX_IDX_PORT_A_PIN6] = slave;
        alt_sel[`PMX_IDX_PORT_A_PIN7] = flag_d_use || cs_use;
        alt_oe[`PMX_IDX_PORT_A_PIN7] = flag_d_use;
        alt_out[`PMX_IDX_PORT_A_PIN7] = flag_d_value;
        // Data lines drive only when the master allows it in slave mode
        for (int i = `PMX_IDX_PORT_B_PIN0; i <= `PMX_IDX_PORT_B_PIN2; i++) begin
            alt_sel[i] = bus;
            alt_out[i] = fifo_data_out[i - `PMX_IDX_PORT_B_PIN0];
            alt_oe[i] = fifo_data_drive && (!slave || (oe_act && cs_act));
        end
    end

    // Pin cells
    generate
        for (genvar g = 0; g < `PMX_NPINS; g++) begin : g_pin
            pmx_pin_cell pmx_pin_cell_i (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .alt_sel(alt_sel[g]),
                .alt_out(alt_out[g]),
                .alt_oe(alt_oe[g]),
                .gp_out(gp_out[g]),
                .gp_oe(gp_oe[g]),
                .pin_i(bif.pin_lvl[g]),
                .pin_o_ff(pin_o[g]),
                .pin_oe_ff(pin_oe[g]),
                .pin_in_ff(pin_in[g])
            );
        end
    endgenerate

    assign bif.dev_o = pin_o;
    assign bif.dev_oe = pin_oe;
    assign port_a_in = pin_in[`PMX_IDX_PORT_A_PIN7:`PMX_IDX_PORT_A_PIN2];
    assign port_b_in = pin_in[`PMX_IDX_PORT_B_PIN2:`PMX_IDX_PORT_B_PIN0];
    assign fifo_data_in = pin_in[`PMX_IDX_PORT_B_PIN2:`PMX_IDX_PORT_B_PIN0];

    // Slave FIFO strobes toward the core, gated by chip select
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            slave_oe_ff <= `PMX_RST_FLAG;
            commit_ff <= `PMX_RST_FLAG;
            cs_ff <= `PMX_RST_FLAG;
        end else begin
            slave_oe_ff <= slave && cs_act && oe_act;
            commit_ff <= slave && cs_act && commit_act;
            cs_ff <= slave && cs_act;
        end
    end

    // FIFO address selects, held at zero outside slave mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fifo_sel_ff <= 2'h0;
        end else if (slave) begin
            fifo_sel_ff <= pin_in[`PMX_IDX_PORT_A_PIN5:`PMX_IDX_PORT_A_PIN4];
        end else begin
            fifo_sel_ff <= 2'h0;
        end
    end

    // Wake pin history; edges counted only once two real samples exist,
    // so the reset level of the history never fakes a transition
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wake_prev_ff <= `PMX_RST_LVL;
            wake_arm_ff <= 1'b0;
            wake_vld_ff <= 1'b0;
        end else begin
            wake_prev_ff <= wake_lvl;
            wake_arm_ff <= 1'b1;
            wake_vld_ff <= wake_arm_ff;
        end
    end

    // Wake events and suspend refusal
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            osc_restart_ff <= `PMX_RST_FLAG;
            irq_ff <= `PMX_RST_FLAG;
            inhibit_ff <= `PMX_RST_FLAG;
        end else begin
            osc_restart_ff <= wake_use && second_wake_gate && cpu_suspended
                && wake_vld_ff && (wake_lvl != wake_prev_ff);
            irq_ff <= wake_use && second_wake_gate && cpu_suspended
                && wake_vld_ff && (wake_lvl != wake_prev_ff);
            inhibit_ff <= wake_use && second_wake_gate && wake_asserted;
        end
    end

    assign slave_out_enable = slave_oe_ff;
    assign packet_commit = commit_ff;
    assign chip_selected = cs_ff;
    assign fifo_select = fifo_sel_ff;
    assign wake_osc_restart = osc_restart_ff;
    assign wake_irq = irq_ff;
    assign suspend_inhibit = inhibit_ff;
endmodule

// [hw/pmx_master.sv]
// Far end: external FIFO master driving the slave strobes and data lines.
// Assumes the user side holds requests steady for the cycles it needs.
`timescale 1ns/10ps
`include "pmx_consts.svh"

module pmx_master (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    pmx_if.mst bif, // Pins toward the device
    input wire logic cfg_slave, // Device is in slave FIFO mode
    input wire logic cfg_chip_select, // Pin 7 is chip select, not flag D
    input wire logic oe_active_high, // Output-enable polarity
    input wire logic commit_active_high, // Packet commit polarity
    input wire logic oe_req, // Ask device to drive data
    input wire logic [1:0] fifo_sel_req, // FIFO to address
    input wire logic commit_req, // Commit the partial packet
    input wire logic cs_req, // Select the device
    input wire pmx_pkg::pmx_data_t wr_data, // Data to drive
    input wire logic wr_drive, // Drive data lines
    input wire logic wake_drive, // Drive the wake pin
    input wire logic wake_level, // Level for the wake pin
    output logic flag_d_seen, // Sampled flag D
    output pmx_pkg::pmx_data_t rd_data // Sampled data lines
);
    import pmx_pkg::*;

    pmx_pins_t o_ff;
    pmx_pins_t oe_ff;
    logic flag_ff;
    pmx_data_t rd_ff;

    // Drive strobes; data only while the device is not asked to drive
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            o_ff <= '0;
            oe_ff <= '0;
        end else begin
            o_ff[`PMX_IDX_PORT_A_PIN2] <= oe_active_high ? oe_req : ~oe_req;
            o_ff[`PMX_IDX_PORT_A_PIN3] <= wake_level;
            o_ff[`PMX_IDX_PORT_A_PIN5:`PMX_IDX_PORT_A_PIN4] <= fifo_sel_req;
            o_ff[`PMX_IDX_PORT_A_PIN6] <= commit_active_high ? commit_req : ~commit_req;
            o_ff[`PMX_IDX_PORT_A_PIN7] <= ~cs_req;
            o_ff[`PMX_IDX_PORT_B_PIN2:`PMX_IDX_PORT_B_PIN0] <= wr_data;
            oe_ff[`PMX_IDX_PORT_A_PIN2] <= cfg_slave;
            oe_ff[`PMX_IDX_PORT_A_PIN3] <= wake_drive;
            oe_ff[`PMX_IDX_PORT_A_PIN5:`PMX_IDX_PORT_A_PIN4] <= {2{cfg_slave}};
            oe_ff[`PMX_IDX_PORT_A_PIN6] <= cfg_slave;
            oe_ff[`PMX_IDX_PORT_A_PIN7] <= cfg_slave && cfg_chip_select;
            oe_ff[`PMX_IDX_PORT_B_PIN2:`PMX_IDX_PORT_B_PIN0] <= {3{cfg_slave && wr_drive && !oe_req}};
        end
    end

    // Sample flag D and the data lines
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
            rd_ff <= 3'h0;
        end else begin
            flag_ff <= bif.pin_lvl[`PMX_IDX_PORT_A_PIN7];
            rd_ff <= bif.pin_lvl[`PMX_IDX_PORT_B_PIN2:`PMX_IDX_PORT_B_PIN0];
        end
    end

    assign bif.mst_o = o_ff;
    assign bif.mst_oe = oe_ff;
    assign flag_d_seen = flag_ff;
    assign rd_data = rd_ff;
endmodule

// [dv/pmx_properties.sv]
// Checker for the pin mux: device drives, and strobes and wake outputs against wire levels.
// Assumes it is instantiated beside the carrier in the bench top.
`timescale 1ns/10ps
`include "pmx_consts.svh"

module pmx_properties (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire pmx_pkg::pmx_pins_t dev_o, // Device drive
    input wire pmx_pkg::pmx_pins_t dev_oe, // Device enable
    input wire pmx_pkg::pmx_pins_t pin_lvl, // Wire level
    input wire logic [1:0] interface_config, // Mode
    input wire logic [5:4] fifo_pin_polarity, // Polarities
    input wire logic port_a_alt_config7, // Flag D select
    input wire logic second_wake_select, // Wake select
    input wire logic second_wake_gate, // Wake gate
    input wire logic second_wake_polarity, // Wake polarity
    input wire logic [7:2] port_a_out, // Port A latch
    input wire logic [7:2] port_a_direction, // Port A dir
    input wire logic [2:0] port_b_out, // Port B latch
    input wire logic [2:0] port_b_direction, // Port B dir
    input wire pmx_pkg::pmx_data_t fifo_data_out, // Core data
    input wire logic fifo_data_drive, // Core drives
    input wire logic flag_d_value, // Flag D
    input wire logic cpu_suspended, // Suspended
    input wire logic [1:0] fifo_select, // Selects
    input wire logic slave_out_enable, // Output enable
    input wire logic packet_commit, // Commit
    input wire logic wake_osc_restart, // Restart pulse
    input wire logic wake_irq, // Wake pulse
    input wire logic suspend_inhibit // Inhibit
);
    import pmx_pkg::*;
    // Decoded modes
    wire slv = interface_config == `PMX_IFC_SLAVE;
    wire wk = second_wake_select && !port_a_direction[3];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_reset_idle;
        disable iff (1'b0) !rst_n |=> dev_oe == 9'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset");
    property p_slave_pins;
        slv |=> !(dev_oe[0] | dev_oe[2] | dev_oe[3] | dev_oe[4]) && dev_oe[5] == $past(port_a_alt_config7);
    endproperty
    a_slave_pins: assert property (p_slave_pins) else $error("slave input pin driven");
    property p_flag_d;
        slv && port_a_alt_config7 |=> dev_o[5] == $past(flag_d_value);
    endproperty
    a_flag_d: assert property (p_flag_d) else $error("flag D value wrong");
    property p_cs_gate;
        (slv && !port_a_alt_config7 && pin_lvl[5]) [*3] |-> !packet_commit && !slave_out_enable;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("strobe passed while deselected");
    property p_polarity;
        (slv && port_a_alt_config7 && $stable(fifo_pin_polarity)) [*3] |->
            slave_out_enable == ($past(pin_lvl[0], 2) == fifo_pin_polarity[4]) &&
            packet_commit == ($past(pin_lvl[4], 2) == fifo_pin_polarity[5]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("strobe polarity wrong");
    property p_select;
        slv [*3] |-> fifo_select == $past(pin_lvl[3:2], 2);
    endproperty
    a_select: assert property (p_select) else $error("fifo select wrong");
    property p_not_slave;
        (!slv) [*3] |-> fifo_select == 2'h0 && !packet_commit && !slave_out_enable;
    endproperty
    a_not_slave: assert property (p_not_slave) else $error("strobe outside slave mode");
    property p_data_bus;
        interface_config == `PMX_IFC_BUS && fifo_data_drive |=>
            dev_oe[8:6] == 3'h7 && dev_o[8:6] == $past(fifo_data_out);
    endproperty
    a_data_bus: assert property (p_data_bus) else $error("data bus not driven");
    property p_port_bits;
        interface_config == `PMX_IFC_PORTS |=> dev_oe == $past({port_b_direction, port_a_direction}) &&
            (dev_o & dev_oe) == ($past({port_b_out, port_a_out}) & dev_oe);
    endproperty
    a_port_bits: assert property (p_port_bits) else $error("port bit wrong");
    property p_wake_input;
        wk |=> !dev_oe[1];
    endproperty
    a_wake_input: assert property (p_wake_input) else $error("wake pin driven");
    property p_inhibit;
        $stable({wk, second_wake_gate, second_wake_polarity}) [*3] |->
            suspend_inhibit == (wk && second_wake_gate && $past(pin_lvl[1], 2) == second_wake_polarity);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("suspend inhibit wrong");
    property p_wake_pulse;
        wk && second_wake_gate && cpu_suspended && $changed(pin_lvl[1]) ##1
            (wk && second_wake_gate && cpu_suspended) |=> wake_irq && wake_osc_restart;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse missing");
    property p_no_wake;
        (!second_wake_gate || !cpu_suspended) [*3] |-> !wake_irq && !wake_osc_restart;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake pulse unexpected");
endmodule

// [dv/port_ab_fifo_pin_mux_bench.sv]
// Self-checking bench: device and FIFO master joined by the pin carrier.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`include "pmx_consts.svh"

module port_ab_fifo_pin_mux_bench;
    import pmx_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] interface_config, fifo_select, fifo_sel_req;
    logic [5:4] fifo_pin_polarity;
    logic [7:2] port_a_out, port_a_direction, port_a_in;
    logic [2:0] port_b_out, port_b_direction, port_b_in;
    pmx_data_t fifo_data_out, fifo_data_in, wr_data, rd_data;
    logic port_a_alt_config7, second_wake_select, second_wake_gate, second_wake_polarity;
    logic fifo_data_drive, flag_d_value, cpu_suspended, slave_out_enable, packet_commit, chip_selected;
    logic wake_osc_restart, wake_irq, suspend_inhibit, oe_active_high, commit_active_high;
    logic oe_req, commit_req, cs_req, wr_drive, wake_drive, wake_level, flag_d_seen;
    logic [8:0] lvl, e;
    int fails = 0;
    int comparisons = 0;
    int n;
    // Master settings and expected strobe activity
    wire cfg_slave = interface_config == `PMX_IFC_SLAVE;
    wire cfg_chip_select = !port_a_alt_config7;
    wire sel = port_a_alt_config7 || cs_req;
    wire oe_on = sel && (oe_req ^ oe_active_high ^ fifo_pin_polarity[4]);
    wire cm_on = sel && (commit_req ^ commit_active_high ^ fifo_pin_polarity[5]);

    pmx_if bif ();
    pmx_device pmx_device_i (.*);
    pmx_master pmx_master_i (.*);
    pmx_properties pmx_properties_i (.*, .dev_o(bif.dev_o), .dev_oe(bif.dev_oe), .pin_lvl(bif.pin_lvl));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // Compare and count
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run;
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Random setting of both ends, mode taken in turn
    task automatic randomise(input int i);
        logic [63:0] r;
        r = {$urandom, $urandom};
        interface_config = i[1:0];
        {fifo_pin_polarity, port_a_alt_config7, oe_active_high, commit_active_high, second_wake_select,
            second_wake_gate, second_wake_polarity, port_a_out, port_a_direction, port_b_out,
            port_b_direction} = r[25:0];
        {fifo_data_out, fifo_data_drive, flag_d_value, cpu_suspended, oe_req, fifo_sel_req, commit_req,
            cs_req, wr_data, wr_drive, wake_drive, wake_level} = r[48:32];
        // Corner: chip deselected with both strobes active
        if (i % 16 == 3) begin
            {cs_req, port_a_alt_config7, oe_req, commit_req} = 4'h3;
            oe_active_high = fifo_pin_polarity[4];
            commit_active_high = fifo_pin_polarity[5];
        end
    endtask

    // Expected wire levels: device wins, then master, else pull-up
    function automatic logic [8:0] exp_lvl();
        logic [8:0] d_oe, d_o, m_oe, m_o;
        d_oe = {port_b_direction, port_a_direction};
        d_o = {port_b_out, port_a_out};
        if (cfg_slave) begin
            d_oe[5:0] = {port_a_alt_config7, 3'h0, port_a_direction[3], 1'b0};
            d_o[5] = flag_d_value;
        end
        if (interface_config[1]) begin
            d_oe[8:6] = {3{fifo_data_drive && (!cfg_slave || oe_on)}};
            d_o[8:6] = fifo_data_out;
        end
        m_oe = {{3{cfg_slave && wr_drive && !oe_req}}, cfg_slave && cfg_chip_select, {3{cfg_slave}}, wake_drive,
            cfg_slave};
        m_o = {wr_data, !cs_req, !(commit_req ^ commit_active_high), fifo_sel_req, wake_level,
            !(oe_req ^ oe_active_high)};
        return (d_oe & d_o) | (~d_oe & m_oe & m_o) | (~d_oe & ~m_oe);
    endfunction

    initial begin
        void'($urandom(56969));
        randomise(0);
        wake_drive = 1'b0;
        cpu_suspended = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk(bif.dev_oe, 9'h0);
        chk({port_b_in, port_a_in}, 9'h1ff);
        rst_n = 1'b1;
        // Random settings, every mode code in turn
        for (int i = 0; i < 200; i++) begin
            randomise(i);
            repeat (6) @(negedge clk_sys);
            lvl = exp_lvl();
            chk({port_b_in, port_a_in}, lvl);
            chk({6'h0, fifo_data_in}, {6'h0, lvl[8:6]});
            chk({5'h0, rd_data, flag_d_seen}, {5'h0, lvl[8:6], lvl[5]});
            e = {4'h0, cfg_slave && oe_on, cfg_slave && cm_on, cfg_slave && sel, cfg_slave ? fifo_sel_req : 2'h0};
            chk({4'h0, slave_out_enable, packet_commit, chip_selected, fifo_select}, e);
            e = {8'h0, second_wake_select && !port_a_direction[3] && second_wake_gate};
            chk({8'h0, suspend_inhibit}, e & {8'h0, lvl[1] == second_wake_polarity});
        end
        // Wake pin toggles while suspended: one pulse per pin edge
        interface_config = `PMX_IFC_PORTS;
        port_a_direction[3] = 1'b0;
        {second_wake_select, second_wake_gate, cpu_suspended, wake_drive} = 4'hf;
        repeat (4) @(negedge clk_sys);
        repeat (2) begin
            wake_level = !wake_level;
            n = 0;
            while (n < 8 && wake_irq !== 1'b1) begin
                @(negedge clk_sys);
                n++;
            end
            if (wake_irq !== 1'b1) begin
                fails++;
                complete_run();
            end
            chk({8'h0, wake_osc_restart}, 9'h1);
            @(negedge clk_sys);
            chk({8'h0, wake_irq}, 9'h0);
            repeat (4) @(negedge clk_sys);
        end
        complete_run();
    end
endmodule
